// [src/audio_port_pkg.sv]
// constants and functions used by the serial audio port; the clock-crossing helpers do not import them
// Behaviour
// - tdm samples are 16, 18, 20 or 24 bits long
// - outgoing bits launch on falling bit-clock edges, incoming bits captured on rising edges
// - tdm first-slot msb lands on second rising edge after frame clock rises
// - every tdm slot spans 32 bit clocks, sample msb first at the top
// - a tdm frame holds 16 slots at 512x or 8 slots at 256x
// - incoming tdm slots are steered to converter paths by a routing setting
// - lj/i2s output samples 16 to 24 bits, incoming words always 24 bits
// - self-generated lj/i2s clocks give 32 bit clocks per channel
// - lj msb lands on first rising edge after any frame-clock change
// - lj left channel while frame clock high, right while low
// - i2s msb lands on second rising edge after any frame-clock change
// - i2s left channel while frame clock low, right while high
// - lj/i2s inputs one and two on line a, three and four on line b
// - lj/i2s line a feeds outputs one and two, line b outputs three and four
// - tdm only with clocks from the far end, device never makes tdm clocks
// - tdm adc samples fill the first four slots of output line a
// - with chaining on, later slots carry upstream data from input line b
package audio_port_pkg;
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_I2S = 2'h2;
  localparam logic [1:0] LEN_16 = 2'h0;
  localparam logic [1:0] LEN_18 = 2'h1;
  localparam logic [1:0] LEN_20 = 2'h2;
  localparam logic [1:0] LEN_24 = 2'h3;
  localparam logic [4:0] SAMPLE_BITS = 5'h18;
  localparam logic [5:0] SLOT_BITS = 6'h20;
  localparam int ADC_SLOTS = 4;
  localparam int CHAIN_DELAY = 128;
  localparam logic [9:0] FRAME_BITS_16 = 10'h200;
  localparam logic [9:0] FRAME_BITS_8 = 10'h100;
  localparam logic [9:0] POS_MAX = 10'h3FF;
  localparam int CFG_W = 10;

  function automatic logic [4:0] sample_len(input logic [1:0] code);
    case (code)
      LEN_16: sample_len = 5'h10;
      LEN_18: sample_len = 5'h12;
      LEN_20: sample_len = 5'h14;
      default: sample_len = 5'h18;
    endcase
  endfunction : sample_len

  function automatic logic [23:0] len_mask(input logic [23:0] w, input logic [4:0] len);
    len_mask = w & (24'hFFFFFF << (SAMPLE_BITS - len));
  endfunction : len_mask

  function automatic logic word_bit(input logic [23:0] w, input logic [4:0] idx, input logic [4:0] len);
    word_bit = (idx < len) ? w[5'h17 - idx] : 1'b0;
  endfunction : word_bit
endpackage : audio_port_pkg

// [src/bit_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : bit_sync
`default_nettype wire

// [src/word_handshake_cdc.sv]
// toggle handshake carrying one word between two clock domains
`timescale 1ns/10ps
`default_nettype none
module word_handshake_cdc #(
  parameter int W = 8
) (
  // source side
  input wire logic src_clk_i,
  input wire logic src_rst_i,
  input wire logic src_valid_i,
  input wire logic [W-1:0] src_data_i,
  output logic src_ready_o,
  // destination side
  input wire logic dst_clk_i,
  input wire logic dst_rst_i,
  output logic dst_valid_o,
  output logic [W-1:0] dst_data_o
);
  logic [W-1:0] hold_q;
  logic req_q;
  logic ack_s;
  logic req_s;
  logic req_seen_q;
  logic [W-1:0] data_q;
  logic valid_q;
  wire logic take = src_valid_i & src_ready_o;
  wire logic arrive = req_s ^ req_seen_q;

  assign src_ready_o = (ack_s == req_q);

  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      req_q <= 1'b0;
      hold_q <= '0;
    end else if (take) begin
      req_q <= ~req_q;
      hold_q <= src_data_i;
    end
  end

  bit_sync #(.W(1)) u_req_sync (.clk_i(dst_clk_i), .rst_i(dst_rst_i), .d_i(req_q), .q_o(req_s));
  bit_sync #(.W(1)) u_ack_sync (.clk_i(src_clk_i), .rst_i(src_rst_i), .d_i(req_seen_q), .q_o(ack_s));

  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      req_seen_q <= 1'b0;
      data_q <= '0;
      valid_q <= 1'b0;
    end else begin
      req_seen_q <= req_s;
      valid_q <= arrive;
      if (arrive) data_q <= hold_q;
    end
  end

  assign dst_valid_o = valid_q;
  assign dst_data_o = data_q;
endmodule : word_handshake_cdc
`default_nettype wire

// [src/codec_serial_audio_port.sv]
// serial audio port: tdm, left-justified and i2s framing on a bit-clock domain
`timescale 1ns/10ps
`default_nettype none
module codec_serial_audio_port
  import audio_port_pkg::*;
(
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // configuration levels
  input wire logic [1:0] format_i,
  input wire logic [1:0] sample_len_i,
  input wire logic tdm_16_slot_i,
  input wire logic output_chaining_enable_i,
  input wire logic clock_master_i,
  input wire logic [2:0] dac_source_i,
  // converter samples going out
  input wire logic [23:0] analog_input_one_i,
  input wire logic [23:0] analog_input_two_i,
  input wire logic [23:0] analog_input_three_i,
  input wire logic [23:0] analog_input_four_i,
  input wire logic adc_valid_i,
  output logic adc_ready_o,
  // converter samples coming in
  output logic [23:0] analog_output_one_o,
  output logic [23:0] analog_output_two_o,
  output logic [23:0] analog_output_three_o,
  output logic [23:0] analog_output_four_o,
  output logic dac_valid_o,
  output logic frame_error_o,
  // serial link
  input wire logic link_bit_clk_i,
  input wire logic frame_word_select_clock_i,
  output logic frame_word_select_clock_o,
  output logic frame_word_select_clock_oe_n_o,
  input wire logic serial_in_line_a_i,
  input wire logic serial_in_line_b_i,
  output logic serial_out_line_a_o,
  output logic serial_out_line_b_o
);
  // link-domain reset and configuration
  logic link_rst;
  logic [CFG_W-1:0] cfg_s;

  bit_sync #(.W(1)) u_rst_sync (.clk_i(link_bit_clk_i), .rst_i(1'b0), .d_i(reset_i), .q_o(link_rst));
  bit_sync #(.W(CFG_W)) u_cfg_sync (
    .clk_i(link_bit_clk_i),
    .rst_i(link_rst),
    .d_i({format_i, sample_len_i, tdm_16_slot_i, output_chaining_enable_i, clock_master_i, dac_source_i}),
    .q_o(cfg_s)
  );

  wire logic [1:0] fmt = cfg_s[9:8];
  wire logic [4:0] len = sample_len(cfg_s[7:6]);
  wire logic slots16 = cfg_s[5];
  wire logic chain_en = cfg_s[4];
  wire logic [2:0] src_sel = cfg_s[2:0];
  wire logic tdm = (fmt == FMT_TDM);
  wire logic lj = (fmt == FMT_LJ);
  wire logic master_act = cfg_s[3] & ~tdm;

  // adc samples into the link domain
  logic [95:0] adc_x;
  logic adc_x_valid;
  logic [23:0] adc_cur_q [ADC_SLOTS];

  word_handshake_cdc #(.W(96)) u_adc_cdc (
    .src_clk_i(clk_sys_i),
    .src_rst_i(reset_i),
    .src_valid_i(adc_valid_i),
    .src_data_i({analog_input_four_i, analog_input_three_i, analog_input_two_i, analog_input_one_i}),
    .src_ready_o(adc_ready_o),
    .dst_clk_i(link_bit_clk_i),
    .dst_rst_i(link_rst),
    .dst_valid_o(adc_x_valid),
    .dst_data_o(adc_x)
  );

  // frame clock generation when the device is clock master
  logic [5:0] gen_cnt_q;
  wire logic [5:0] gen_cnt_d = gen_cnt_q + 6'h01;

  always_ff @(negedge link_bit_clk_i) begin
    if (link_rst || !master_act) gen_cnt_q <= 6'h00;
    else gen_cnt_q <= gen_cnt_d;
  end

  assign frame_word_select_clock_o = gen_cnt_q[5];
  assign frame_word_select_clock_oe_n_o = ~master_act;

  // framing position
  logic fs_q;
  logic [9:0] pos_q;
  logic synced_q;
  wire logic fs_lvl = master_act ? gen_cnt_q[5] : frame_word_select_clock_i;
  wire logic fs_rise = fs_lvl & ~fs_q;
  wire logic fs_edge = fs_lvl ^ fs_q;
  wire logic ev = tdm ? fs_rise : fs_edge;
  wire logic [9:0] frame_bits = slots16 ? FRAME_BITS_16 : FRAME_BITS_8;
  wire logic frame_ok = (pos_q == frame_bits - 10'h001);
  wire logic [9:0] cur_pos = (lj && ev) ? 10'h000 : pos_q;
  wire logic [3:0] cur_slot = cur_pos[8:5];
  wire logic [4:0] cur_bit = cur_pos[4:0];
  wire logic left = lj ? fs_lvl : ~fs_lvl;
  wire logic in_word = tdm ? (cur_pos < frame_bits) : (cur_pos[9:5] == 5'h00);

  always_ff @(posedge link_bit_clk_i) begin
    if (link_rst) begin
      fs_q <= 1'b0;
      pos_q <= POS_MAX;
      synced_q <= 1'b0;
    end else begin
      fs_q <= fs_lvl;
      if (ev) begin
        synced_q <= 1'b1;
        pos_q <= lj ? 10'h001 : 10'h000;
      end else if (pos_q != POS_MAX) begin
        pos_q <= pos_q + 10'h001;
      end
    end
  end

  // receive: capture on rising edges
  logic [22:0] rx_a_q;
  logic [22:0] rx_b_q;
  logic [23:0] dac_q [ADC_SLOTS];
  logic [CHAIN_DELAY-1:0] chain_q;
  wire logic [23:0] word_a = len_mask({rx_a_q, serial_in_line_a_i}, tdm ? len : SAMPLE_BITS);
  wire logic [23:0] word_b = len_mask({rx_b_q, serial_in_line_b_i}, tdm ? len : SAMPLE_BITS);
  wire logic word_done = in_word && (cur_bit == SAMPLE_BITS - 5'h01);
  wire logic tdm_hit = tdm && word_done && (cur_slot[3:2] == src_sel[1:0]);
  wire logic pcm_hit = !tdm && word_done;

  always_ff @(posedge link_bit_clk_i) begin
    rx_a_q <= {rx_a_q[21:0], serial_in_line_a_i};
    rx_b_q <= {rx_b_q[21:0], serial_in_line_b_i};
    chain_q <= {chain_q[CHAIN_DELAY-2:0], serial_in_line_b_i};
    if (tdm_hit) begin
      dac_q[cur_slot[1:0]] <= src_sel[2] ? word_b : word_a;
    end
    if (pcm_hit) begin
      dac_q[{1'b0, ~left}] <= word_a;
      dac_q[{1'b1, ~left}] <= word_b;
    end
  end

  // completed frames go back to the system domain
  wire logic pub_tdm = tdm && ev && synced_q;
  wire logic pub_pcm = !tdm && ev && left && synced_q;
  wire logic pub = pub_tdm || pub_pcm;
  wire logic pub_err = pub_tdm && !frame_ok;
  logic [96:0] dac_x;
  logic dac_x_valid;

  word_handshake_cdc #(.W(97)) u_dac_cdc (
    .src_clk_i(link_bit_clk_i),
    .src_rst_i(link_rst),
    .src_valid_i(pub),
    .src_data_i({pub_err, dac_q[3], dac_q[2], dac_q[1], dac_q[0]}),
    .src_ready_o(),
    .dst_clk_i(clk_sys_i),
    .dst_rst_i(reset_i),
    .dst_valid_o(dac_x_valid),
    .dst_data_o(dac_x)
  );

  // adc words reloaded at each framing event: once per tdm frame, once per channel in lj/i2s
  logic [95:0] adc_pend_q;

  always_ff @(posedge link_bit_clk_i) begin
    if (link_rst) begin
      adc_pend_q <= '0;
      for (int i = 0; i < ADC_SLOTS; i++) adc_cur_q[i] <= 24'h000000;
    end else begin
      if (adc_x_valid) adc_pend_q <= adc_x;
      if (ev) begin
        for (int i = 0; i < ADC_SLOTS; i++) adc_cur_q[i] <= adc_pend_q[24*i +: 24];
      end
    end
  end

  // transmit: launch on falling edges
  wire logic [5:0] gen_nxt_hi = master_act ? gen_cnt_d : {frame_word_select_clock_i, 5'h00};
  wire logic fs_nxt = gen_nxt_hi[5];
  wire logic tx_first = lj && (fs_nxt != fs_q);
  wire logic [9:0] tx_pos = tx_first ? 10'h000 : pos_q;
  wire logic tx_fs = lj ? fs_nxt : fs_q;
  wire logic tx_left = lj ? tx_fs : ~tx_fs;
  wire logic [3:0] tx_slot = tx_pos[8:5];
  wire logic [4:0] tx_bit = tx_pos[4:0];
  wire logic tdm_adc = tx_pos < {4'h0, SLOT_BITS} * 10'h004;
  wire logic tdm_chain = chain_en && !tdm_adc && (tx_pos < frame_bits);
  wire logic tdm_a = tdm_adc ? word_bit(adc_cur_q[tx_slot[1:0]], tx_bit, len)
                   : (tdm_chain ? chain_q[CHAIN_DELAY-1] : 1'b0);
  wire logic pcm_word = (tx_pos[9:5] == 5'h00);
  wire logic pcm_a = pcm_word && word_bit(adc_cur_q[{1'b0, ~tx_left}], tx_bit, len);
  wire logic pcm_b = pcm_word && word_bit(adc_cur_q[{1'b1, ~tx_left}], tx_bit, len);
  logic out_a_q;
  logic out_b_q;

  always_ff @(negedge link_bit_clk_i) begin
    if (link_rst) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      out_a_q <= tdm ? tdm_a : pcm_a;
      out_b_q <= tdm ? 1'b0 : pcm_b;
    end
  end

  assign serial_out_line_a_o = out_a_q;
  assign serial_out_line_b_o = out_b_q;

  // system-domain results
  logic [23:0] aout_q [ADC_SLOTS];
  logic dac_valid_q;
  logic err_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dac_valid_q <= 1'b0;
      err_q <= 1'b0;
      for (int i = 0; i < ADC_SLOTS; i++) aout_q[i] <= 24'h000000;
    end else begin
      dac_valid_q <= dac_x_valid && !dac_x[96];
      err_q <= dac_x_valid && dac_x[96];
      if (dac_x_valid && !dac_x[96]) begin
        for (int i = 0; i < ADC_SLOTS; i++) aout_q[i] <= dac_x[24*i +: 24];
      end
    end
  end

  assign analog_output_one_o = aout_q[0];
  assign analog_output_two_o = aout_q[1];
  assign analog_output_three_o = aout_q[2];
  assign analog_output_four_o = aout_q[3];
  assign dac_valid_o = dac_valid_q;
  assign frame_error_o = err_q;

  // checks
  sequence tdm_frame_end_s;
    tdm && ev && synced_q;
  endsequence

  sequence tdm_bad_len_s;
    tdm_frame_end_s ##0 !frame_ok;
  endsequence

  a_tdm_msb_pos: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    tdm && fs_rise |=> pos_q == 10'h000)
    else $error("tdm frame start did not restart the bit position");

  a_lj_msb_pos: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    lj && fs_edge |=> pos_q == 10'h001)
    else $error("lj frame clock change did not place msb on that edge");

  a_i2s_msb_pos: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    (fmt == FMT_I2S) && fs_edge |=> pos_q == 10'h000)
    else $error("i2s frame clock change did not delay msb by one edge");

  a_slot_count: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    !ev && pos_q < 10'h3F0 ##1 !ev |-> pos_q == $past(pos_q) + 10'h001)
    else $error("bit position did not advance by one");

  a_frame_publish: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    tdm_frame_end_s |-> pub && (pub_err == !frame_ok))
    else $error("tdm frame end not reported");

  a_bad_len_err: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    tdm_bad_len_s |-> pub_err)
    else $error("short or long tdm frame not flagged");

  a_idle_zero: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    $stable(cfg_s) && tdm && !chain_en && !ev && pos_q >= 10'h080 |-> !serial_out_line_a_o)
    else $error("idle tdm slot not zero");

  a_adc_low_zero: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    $stable(cfg_s) && tdm && pos_q < 10'h080 && pos_q[4:0] >= len |-> !serial_out_line_a_o)
    else $error("adc slot bits below the sample length not zero");

  a_chain_fwd: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    $stable(cfg_s) && tdm && chain_en && pos_q >= 10'h080 && pos_q < frame_bits
      |-> serial_out_line_a_o == chain_q[CHAIN_DELAY-1])
    else $error("chained slot does not carry upstream data");

  a_no_tdm_master: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    tdm |-> frame_word_select_clock_oe_n_o)
    else $error("frame clock driven in tdm framing");

  a_master_half: assert property (@(negedge link_bit_clk_i) disable iff (link_rst)
    master_act && $stable(cfg_s) && gen_cnt_q[4:0] == 5'h1F |=> $changed(frame_word_select_clock_o))
    else $error("generated channel not 32 bit clocks long");

  a_pcm_route: assert property (@(posedge link_bit_clk_i) disable iff (link_rst)
    pcm_hit && left |=> dac_q[0] == $past(word_a) && dac_q[2] == $past(word_b))
    else $error("left input words not routed to outputs one and three");
endmodule : codec_serial_audio_port
`default_nettype wire

// [verification/audio_host_model.sv]
// far-end host model: makes the link clocks, drives words in, captures words out
`timescale 1ns/10ps
`default_nettype none
module audio_host_model (
  // link clocks
  output logic bclk_o,
  output logic fclk_o,
  // data toward the port
  output logic sd_a_o,
  output logic sd_b_o,
  // data from the port
  input wire logic sd_a_i,
  input wire logic sd_b_i
);
  logic [23:0] in_a [16];
  logic [23:0] in_b [16];
  logic [31:0] cap_a [16];
  logic [31:0] cap_b [16];
  realtime end_t = -1.0;

  initial begin
    bclk_o = 1'b0;
    fclk_o = 1'b0;
    sd_a_o = 1'b0;
    sd_b_o = 1'b0;
  end

  // bit clock always comes from this side, 6 ns
  always #3 bclk_o = ~bclk_o;

  // frame clock level for bit e of a frame
  function automatic logic fsv(input int fmt, input int e);
    fsv = (fmt == 0) ? (e == 0) : ((fmt == 1) == (e < 32));
  endfunction : fsv

  // fmt 0 tdm, 1 lj, 2 i2s; first frame short by sh bits
  // frame clock moves after a rising edge so the port sees it at the next falling edge
  // calls back to back continue without a gap bit
  task automatic frames(input int fmt, input int ns, input int cnt, input int sh);
    int n;
    int d;
    int p;
    int m;
    n = ns * 32;
    d = (fmt == 1) ? 0 : 1;
    if ($realtime != end_t) @(posedge bclk_o);
    fclk_o <= fsv(fmt, 0);
    for (int f = 0; f < cnt; f++) begin
      m = n - ((f == 0) ? sh : 0);
      for (int e = 0; e < m; e++) begin
        @(negedge bclk_o);
        p = (e + n - d) % n;
        sd_a_o <= (p % 32 < 24) ? in_a[p / 32][23 - p % 32] : 1'b0;
        sd_b_o <= (p % 32 < 24) ? in_b[p / 32][23 - p % 32] : 1'b0;
        @(posedge bclk_o);
        cap_a[p / 32][31 - p % 32] = sd_a_i;
        cap_b[p / 32][31 - p % 32] = sd_b_i;
        if (f < cnt - 1 || e < m - 1) fclk_o <= fsv(fmt, (e + 1) % m);
      end
    end
    end_t = $realtime;
  endtask : frames
endmodule : audio_host_model
`default_nettype wire

// [verification/codec_serial_audio_port_test.sv]
// self-checking bench for the serial audio port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module codec_serial_audio_port_test;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] fmt = 2'h0;
  logic [1:0] len = 2'h0;
  logic n16 = 1'b0;
  logic chain = 1'b0;
  logic [2:0] src = 3'h0;
  logic [23:0] adc [4] = '{default: 24'h0};
  logic adc_valid = 1'b0;
  logic mst = 1'b0;
  wire logic fclk_gen;
  wire logic fclk_oe_n;
  logic [23:0] ia [16];
  logic [23:0] ib [16];
  wire logic adc_ready;
  wire logic dac_valid;
  wire logic frame_error;
  wire logic bclk;
  wire logic fclk;
  wire logic sd_in_a;
  wire logic sd_in_b;
  wire logic sd_out_a;
  wire logic sd_out_b;
  wire logic [23:0] d1;
  wire logic [23:0] d2;
  wire logic [23:0] d3;
  wire logic [23:0] d4;
  logic [95:0] notes [$];
  logic [95:0] last_n = '0;
  logic watch = 1'b0;
  int err_n = 0;
  int fail_count = 0;
  int checks = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  codec_serial_audio_port codec_serial_audio_port_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .format_i(fmt), .sample_len_i(len), .tdm_16_slot_i(n16),
    .output_chaining_enable_i(chain), .clock_master_i(mst), .dac_source_i(src),
    .analog_input_one_i(adc[0]), .analog_input_two_i(adc[1]),
    .analog_input_three_i(adc[2]), .analog_input_four_i(adc[3]),
    .adc_valid_i(adc_valid), .adc_ready_o(adc_ready),
    .analog_output_one_o(d1), .analog_output_two_o(d2),
    .analog_output_three_o(d3), .analog_output_four_o(d4),
    .dac_valid_o(dac_valid), .frame_error_o(frame_error),
    .link_bit_clk_i(bclk), .frame_word_select_clock_i(fclk),
    .frame_word_select_clock_o(fclk_gen), .frame_word_select_clock_oe_n_o(fclk_oe_n),
    .serial_in_line_a_i(sd_in_a), .serial_in_line_b_i(sd_in_b),
    .serial_out_line_a_o(sd_out_a), .serial_out_line_b_o(sd_out_b)
  );

  audio_host_model audio_host_model_i (
    .bclk_o(bclk), .fclk_o(fclk), .sd_a_o(sd_in_a), .sd_b_o(sd_in_b),
    .sd_a_i(sd_out_a), .sd_b_i(sd_out_b)
  );

  function automatic logic [23:0] msk(input logic [23:0] w, input logic [1:0] c);
    msk = w & ~(24'hFFFFFF >> ((c == 2'h3) ? 24 : 16 + 2 * c));
  endfunction : msk

  task automatic end_of_test();
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // received words against the oldest note
  always @(posedge clk_sys_i) begin
    if (frame_error === 1'b1) err_n++;
    if (watch && dac_valid === 1'b1) begin
      if (notes.size() > 0) last_n = notes.pop_front();
      `CHK({d1, d2, d3, d4}, last_n)
    end
  end

  task automatic run(input int f, input int l, input int ns, input logic ch, input int sh);
    logic [95:0] exp;
    logic [31:0] wa;
    logic [31:0] wb;
    int b;
    int e0;
    int i;
    @(posedge clk_sys_i);
    fmt <= f[1:0];
    len <= l[1:0];
    n16 <= (ns == 16);
    chain <= ch;
    src <= {1'($urandom % 2), 2'($urandom % (ns > 8 ? 4 : 2))};
    adc_valid <= 1'b1;
    for (i = 0; i < 4; i++) adc[i] <= 24'($urandom);
    for (i = 0; i < 16; i++) begin
      ia[i] = 24'($urandom);
      ib[i] = 24'($urandom);
    end
    audio_host_model_i.in_a = ia;
    audio_host_model_i.in_b = ib;
    @(negedge clk_sys_i);
    for (i = 0; i < 50 && adc_ready !== 1'b1; i++) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    adc_valid <= 1'b0;
    if (i == 50) begin
      fail_count++;
      end_of_test();
    end
    b = src[1:0] * 4;
    for (i = 0; i < 4; i++) begin
      if (f == 0) exp[95 - 24 * i -: 24] = msk(src[2] ? ib[b + i] : ia[b + i], l[1:0]);
      else exp[95 - 24 * i -: 24] = (i < 2) ? ia[i] : ib[i - 2];
    end
    audio_host_model_i.frames(f, ns, 2, 0);
    notes.push_back(exp);
    e0 = err_n;
    watch = 1'b1;
    audio_host_model_i.frames(f, ns, 3, sh);
    repeat (20) @(posedge clk_sys_i);
    watch = 1'b0;
    `CHK(notes.size(), 0)
    `CHK(err_n - e0, sh)
    for (i = 0; i < ns; i++) begin
      wb = (f == 0) ? 32'h0 : {msk(adc[i + 2], l[1:0]), 8'h0};
      if (i < 4) wa = {msk(adc[i], l[1:0]), 8'h0};
      else wa = chain ? {ib[i - 4], 8'h0} : 32'h0;
      `CHK(audio_host_model_i.cap_a[i], wa)
      `CHK(audio_host_model_i.cap_b[i], wb)
    end
  endtask : run

  // device as frame clock master: pin enabled, 32 bit clocks per channel
  task automatic master_check();
    int n;
    logic last;
    `CHK(fclk_oe_n, 1'b1)
    @(posedge clk_sys_i);
    fmt <= 2'h1;
    mst <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    `CHK(fclk_oe_n, 1'b0)
    @(negedge bclk);
    last = fclk_gen;
    for (n = 0; n < 100 && fclk_gen === last; n++) @(negedge bclk);
    last = fclk_gen;
    for (n = 0; n < 100 && fclk_gen === last; n++) @(negedge bclk);
    `CHK(n, 32)
    @(posedge clk_sys_i);
    mst <= 1'b0;
  endtask : master_check

  initial begin
    void'($urandom(32'hb86b0868));
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    // every tdm length code, both frame sizes, chaining on and off, one short frame
    for (int k = 0; k < 4; k++) run(0, k, (k % 2 == 1) ? 16 : 8, 1'(k % 2 != k / 2), (k == 3) ? 1 : 0);
    // left-justified then i2s
    for (int f = 1; f < 3; f++) run(f, $urandom % 4, 2, 1'b0, 0);
    master_check();
    end_of_test();
  end
endmodule : codec_serial_audio_port_test
`default_nettype wire
